//--- verification/pin_verify_change_disable_tb.sv
`timescale 1ns/1ps
module pin_verify_change_disable_tb;
    logic        clock;
    logic        rst;
    logic        sess;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] v;
    int          n_fail;
    int          n_checks;
    int          cycles;
    localparam logic [63:0] PV = pvc_pkg::VALUE_RESET;
    localparam logic [63:0] NV = 64'h1234_5678_9ABC_DEF0;
    localparam logic [63:0] XV = 64'h0000_0000_0000_0001;
    localparam logic [6:0]  EMP = 7'h40;
    localparam logic [7:0]  BADQ [3] = '{8'h00, 8'hC5, 8'hA5};

    pvc_if   i_pvc_if (.clock(clock), .rst(rst));
    pvc_card i_pvc_card (.link(i_pvc_if), .session_start(sess));
    pvc_term i_pvc_term (.link(i_pvc_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    pvc_chk  i_pvc_chk (.clock(clock), .rst(rst), .cmd_valid(i_pvc_if.cmd_valid),
        .cmd_op(i_pvc_if.cmd_op), .cmd_p1(i_pvc_if.cmd_p1), .cmd_p2(i_pvc_if.cmd_p2),
        .cmd_lc(i_pvc_if.cmd_lc), .rsp_valid(i_pvc_if.rsp_valid), .rsp_sw(i_pvc_if.rsp_sw),
        .acc_req(i_pvc_if.acc_req), .acc_qual_a(i_pvc_if.acc_qual_a),
        .acc_two(i_pvc_if.acc_two), .acc_valid(i_pvc_if.acc_valid),
        .acc_grant(i_pvc_if.acc_grant));

    // ----------------------------------------
    // Register port and compare tasks
    // ----------------------------------------
    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // x holds empty flag, replacement flag and key number
    task automatic cmd(input logic [1:0] op, input logic [7:0] p2, input logic [6:0] x,
        input logic [63:0] o, input logic [63:0] n, input logic [15:0] e);
        logic [31:0] s;
        wr_reg(pvc_pkg::OFS_OLD_HI, o[63:32]);
        wr_reg(pvc_pkg::OFS_OLD_LO, o[31:0]);
        wr_reg(pvc_pkg::OFS_NEW_HI, n[63:32]);
        wr_reg(pvc_pkg::OFS_NEW_LO, n[31:0]);
        wr_reg(pvc_pkg::OFS_CMD, {8'h00, p2, 3'h0, x[4:0], 4'h0, x[5], x[6], op});
        for (int i = 0; i < 16; i++) begin
            rd_reg(pvc_pkg::OFS_STATUS, s);
            if (s[16] === 1'b1) break;
        end
        chk_val("status", {14'h0, 2'b01, e}, {14'h0, s[17:0]});
    endtask
    task automatic acc(input logic [7:0] a, input logic [7:0] b, input logic t, input logic g);
        logic [31:0] s;
        wr_reg(pvc_pkg::OFS_ACC, {15'h0, t, b, a});
        // Result lands one cycle after the answer
        @(posedge clock);
        rd_reg(pvc_pkg::OFS_ACC_RES, s);
        chk_val("grant", {30'h0, 2'b10 | {1'b0, g}}, {30'h0, s[1:0]});
    endtask
    task automatic pulse();
        @(posedge clock);
        sess <= 1'b1;
        @(posedge clock);
        sess <= 1'b0;
    endtask

    // ----------------------------------------
    // Clock, timeout and tests
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        {sess, addr, wdata, wr, rd, n_fail, n_checks, cycles} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        wr_reg(pvc_pkg::OFS_NEW_HI, 32'h5A5A_0F0F);
        rd_reg(pvc_pkg::OFS_NEW_HI, v);
        chk_val("register", 32'h5A5A_0F0F, v);
        rd_reg(8'hFC, v);
        chk_val("unmapped", 32'h0000_0000, v);
        cmd(2'h0, 8'h81, 7'h00, PV, PV, pvc_pkg::SW_OK);
        acc(8'h81, 8'h00, 1'b0, 1'b1);
        pulse();
        acc(8'h81, 8'h00, 1'b0, 1'b0);
        acc(8'h00, 8'h00, 1'b0, 1'b0);
        $display("test access done");
        for (int i = 2; i >= 0; i--) begin
            cmd(2'h0, 8'h81, 7'h00, XV, XV, {12'h63C, 4'(i)});
            pulse();
        end
        cmd(2'h0, 8'h81, EMP, XV, XV, 16'h63C0);
        cmd(2'h0, 8'h81, 7'h00, PV, PV, pvc_pkg::SW_BLOCKED);
        acc(8'h81, 8'h00, 1'b0, 1'b0);
        cmd(2'h2, 8'h81, 7'h00, PV, PV, pvc_pkg::SW_REFUSED);
        $display("test blocking done");
        cmd(2'h1, 8'h82, 7'h00, XV, NV, 16'h63C2);
        cmd(2'h1, 8'h82, 7'h00, PV, NV, pvc_pkg::SW_OK);
        cmd(2'h0, 8'h82, EMP, NV, NV, 16'h63C3);
        cmd(2'h0, 8'h82, 7'h00, NV, NV, pvc_pkg::SW_OK);
        for (int i = 2; i >= 0; i--) begin
            cmd(2'h1, 8'h82, 7'h00, PV, XV, {12'h63C, 4'(i)});
        end
        cmd(2'h0, 8'h82, 7'h00, NV, NV, pvc_pkg::SW_BLOCKED);
        $display("test change done");
        cmd(2'h2, 8'h83, 7'h00, XV, XV, 16'h63C2);
        acc(8'h83, 8'h00, 1'b0, 1'b0);
        cmd(2'h2, 8'h83, 7'h00, PV, PV, pvc_pkg::SW_OK);
        acc(8'h83, 8'h00, 1'b0, 1'b1);
        cmd(2'h2, 8'h83, 7'h00, PV, PV, pvc_pkg::SW_REFUSED);
        cmd(2'h0, 8'h83, 7'h00, PV, PV, pvc_pkg::SW_REFUSED);
        cmd(2'h0, 8'h83, EMP, PV, PV, 16'h63C3);
        cmd(2'h2, 8'h84, 7'h22, PV, PV, pvc_pkg::SW_OK);
        acc(8'h84, 8'h00, 1'b0, 1'b0);
        cmd(2'h0, 8'h02, 7'h00, PV, PV, pvc_pkg::SW_OK);
        acc(8'h84, 8'h00, 1'b0, 1'b1);
        acc(8'h05, 8'h83, 1'b1, 1'b1);
        $display("test disable done");
        cmd(2'h3, 8'h85, 7'h00, XV, XV, pvc_pkg::SW_BAD_OP);
        foreach (BADQ[i]) cmd(2'h0, BADQ[i], 7'h00, XV, XV, pvc_pkg::SW_BAD_PARAM);
        cmd(2'h2, 8'h85, 7'h20, XV, XV, pvc_pkg::SW_BAD_PARAM);
        cmd(2'h0, 8'h85, EMP, XV, XV, 16'h63C3);
        $display("test refusal done");
        stop_test();
    end
endmodule

//--- verification/pvc_chk_sva.sv
`timescale 1ns/1ps
module pvc_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic [1:0]  cmd_op,
    input wire logic [7:0]  cmd_p1,
    input wire logic [7:0]  cmd_p2,
    input wire logic [7:0]  cmd_lc,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_sw,
    input wire logic        acc_req,
    input wire logic [7:0]  acc_qual_a,
    input wire logic        acc_two,
    input wire logic        acc_valid,
    input wire logic        acc_grant
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Command steps
    // ----------------------------------------
    logic bad_q;
    assign bad_q = cmd_p2[6:5] != 2'h0 || cmd_p2[4:0] == 5'h00;
    sequence cmd_s(logic [1:0] op);
        cmd_valid && cmd_op == op;
    endsequence
    sequence answer_s(logic [15:0] sw);
        ##2 rsp_valid && rsp_sw == sw;
    endsequence
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    rsp_timing_a: assert property (cmd_valid |-> ##2 rsp_valid)
        else $error("answer missing two cycles after command");
    rsp_origin_a: assert property (rsp_valid |-> $past(cmd_valid, 2))
        else $error("answer without command");
    sw_hold_a: assert property (!rsp_valid |-> $stable(rsp_sw))
        else $error("status word moved between answers");
    bad_op_a: assert property (cmd_s(2'h3) |-> answer_s(pvc_pkg::SW_BAD_OP))
        else $error("invalid operation not refused");
    bad_qual_a: assert property (cmd_valid && cmd_op != 2'h3 && bad_q
        |-> answer_s(pvc_pkg::SW_BAD_PARAM))
        else $error("bad qualifier not refused");
    bad_repl_a: assert property (cmd_s(2'h2) ##0 (cmd_p1[7] && cmd_p1[4:0] == 5'h00)
        |-> answer_s(pvc_pkg::SW_BAD_PARAM))
        else $error("replacement key zero not refused");
    empty_query_a: assert property (cmd_s(2'h0) ##0 (cmd_lc == 8'h00 && !bad_q)
        |-> ##2 rsp_valid && rsp_sw[15:4] == 12'h63C && rsp_sw[3:0] <= 4'h3)
        else $error("empty verify gave no retry count");
    acc_timing_a: assert property (acc_req |=> acc_valid)
        else $error("access answer late");
    acc_bad_a: assert property (acc_req && !acc_two && (acc_qual_a[6:5] != 2'h0
        || acc_qual_a[4:0] == 5'h00) |=> !acc_grant)
        else $error("invalid qualifier granted");
    len_change_a: assert property (cmd_valid |-> (cmd_op == 2'h1) == (cmd_lc == 8'h10))
        else $error("change length malformed");
    len_value_a: assert property (cmd_valid && cmd_op != 2'h1 |-> cmd_lc == 8'h08 ||
        (cmd_op == 2'h0 && cmd_lc == 8'h00))
        else $error("single value length malformed");
    p1_form_a: assert property (cmd_valid && cmd_op != 2'h2 |-> cmd_p1 == 8'h00)
        else $error("first parameter not zero");
endmodule

//--- verilog/pvc_card.sv
// Functional notes
// - Compare only if reference enabled and unblocked.
// - Protected access needs prior verification unless disabled.
// - Correct verify restores tries to three.
// - Wrong verify decrements; third blocks, 63C0.
// - Verify on blocked reference answers 6983.
// - Blocked reference never grants access.
// - Empty verify reports remaining tries only.
// - Failed unblocked attempt reports remaining tries.
// - Terminal sends P1 00, length 00/08.
// - Qualifier: scope bit, zero bits, number 1-31.
// - Change uses P1 00, length 10, old/new.
// - Correct change resets tries, stores new value.
// - Wrong change decrements, keeps value, blocks.
// - Disable refused if disabled or blocked.
// - Correct disable resets tries, marks disabled.
// - Wrong disable decrements, stays enabled, blocks.
// - Disabled reference unrestricted unless replacement chosen and access is single-key.
// - Two-key access grants on either listed key disabled, global or specific, whether or not a replacement key was chosen.
// - Replacement key verification gates disabled reference in single-key access only.
// - Disable P1: 00, 01 reserved, replacement key.
// - Disable sends length 08 with value.
`timescale 1ns/1ps
module pvc_card (
    pvc_if.card      link,
    input wire logic session_start
);
    typedef struct packed {
        pvc_pkg::pvc_state_t          state;
        logic                         rsp_valid;
        logic [15:0]                  rsp_sw;
        logic                         acc_valid;
        logic                         acc_grant;
        logic [1:0]                   op;
        logic [7:0]                   p1;
        logic [7:0]                   p2;
        logic [7:0]                   lc;
        logic [127:0]                 data;
        pvc_pkg::pvc_entry_t [63:0]   ent;
    } pvc_card_t;

    pvc_card_t  st_reg;
    pvc_card_t  st_next;
    logic       q_ok;
    logic [5:0] q_idx;
    logic       qa_ok;
    logic [5:0] qa_idx;
    logic       qb_ok;
    logic [5:0] qb_idx;

    pvc_qual u_qual_cmd (
        .qual (st_reg.p2),
        .ok   (q_ok),
        .idx  (q_idx)
    );
    pvc_qual u_qual_a (
        .qual (link.acc_qual_a),
        .ok   (qa_ok),
        .idx  (qa_idx)
    );
    pvc_qual u_qual_b (
        .qual (link.acc_qual_b),
        .ok   (qb_ok),
        .idx  (qb_idx)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic ref_grant(input pvc_pkg::pvc_entry_t e,
                                       input pvc_pkg::pvc_entry_t r);
        if (e.disabled) begin
            ref_grant = !e.repl_use || (r.tries != 2'h0 && r.verified);
        end else begin
            ref_grant = (e.tries != 2'h0) && e.verified;
        end
    endfunction

    function automatic logic [15:0] retry_sw(input logic [1:0] tries);
        retry_sw = pvc_pkg::SW_RETRY | {14'h0000, tries};
    endfunction

    function automatic logic p1_ok(input logic [1:0] op, input logic [7:0] p1);
        if (op == pvc_pkg::OP_DISABLE) begin
            // Value 01 and any scope-less nonzero byte fall out here
            p1_ok = (p1 == pvc_pkg::P1_PLAIN) ||
                    (p1[pvc_pkg::QUAL_SEL_BIT] &&
                     p1[pvc_pkg::QUAL_RSV_MSB:pvc_pkg::QUAL_RSV_LSB] == 2'h0 &&
                     p1[pvc_pkg::QUAL_REF_MSB:0] != 5'h00);
        end else begin
            p1_ok = (p1 == pvc_pkg::P1_PLAIN);
        end
    endfunction

    function automatic logic lc_ok(input logic [1:0] op, input logic [7:0] lc);
        if (op == pvc_pkg::OP_VERIFY) begin
            lc_ok = (lc == pvc_pkg::LC_EMPTY) || (lc == pvc_pkg::LC_ONE_VALUE);
        end else if (op == pvc_pkg::OP_CHANGE) begin
            lc_ok = (lc == pvc_pkg::LC_TWO_VALUE);
        end else begin
            lc_ok = (lc == pvc_pkg::LC_ONE_VALUE);
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        pvc_pkg::pvc_entry_t e;
        pvc_pkg::pvc_entry_t ea;
        pvc_pkg::pvc_entry_t eb;
        logic                match;
        logic                blocked;
        logic                ga;
        logic                gb;
        st_next           = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.acc_valid = 1'b0;
        e       = st_reg.ent[q_idx];
        ea      = st_reg.ent[qa_idx];
        eb      = st_reg.ent[qb_idx];
        match   = (st_reg.data[127:64] == e.value);
        blocked = (e.tries == 2'h0);
        ga      = ref_grant(ea, st_reg.ent[{1'b0, ea.repl_ref}]);
        gb      = ref_grant(eb, st_reg.ent[{1'b0, eb.repl_ref}]);

        case (st_reg.state)
            pvc_pkg::ST_IDLE: begin
                if (link.cmd_valid) begin
                    st_next.op    = link.cmd_op;
                    st_next.p1    = link.cmd_p1;
                    st_next.p2    = link.cmd_p2;
                    st_next.lc    = link.cmd_lc;
                    st_next.data  = link.cmd_data;
                    st_next.state = pvc_pkg::ST_WORK;
                end
            end
            pvc_pkg::ST_WORK: begin
                st_next.state     = pvc_pkg::ST_IDLE;
                st_next.rsp_valid = 1'b1;
                st_next.rsp_sw    = pvc_pkg::SW_OK;
                if (st_reg.op == 2'h3) begin
                    st_next.rsp_sw = pvc_pkg::SW_BAD_OP;
                end else if (!q_ok || !p1_ok(st_reg.op, st_reg.p1)) begin
                    st_next.rsp_sw = pvc_pkg::SW_BAD_PARAM;
                end else if (!lc_ok(st_reg.op, st_reg.lc)) begin
                    st_next.rsp_sw = pvc_pkg::SW_BAD_LEN;
                end else if (st_reg.op == pvc_pkg::OP_VERIFY &&
                             st_reg.lc == pvc_pkg::LC_EMPTY) begin
                    st_next.rsp_sw = retry_sw(e.tries);
                end else if (blocked && st_reg.op != pvc_pkg::OP_DISABLE) begin
                    st_next.rsp_sw = pvc_pkg::SW_BLOCKED;
                end else if (e.disabled || blocked) begin
                    st_next.rsp_sw = pvc_pkg::SW_REFUSED;
                end else if (match) begin
                    e.tries = pvc_pkg::TRIES_INIT;
                    if (st_reg.op == pvc_pkg::OP_DISABLE) begin
                        e.disabled = 1'b1;
                        e.repl_use = st_reg.p1[pvc_pkg::QUAL_SEL_BIT];
                        e.repl_ref = st_reg.p1[pvc_pkg::QUAL_REF_MSB:0];
                    end else begin
                        e.verified = 1'b1;
                        if (st_reg.op == pvc_pkg::OP_CHANGE) begin
                            e.value = st_reg.data[63:0];
                        end
                    end
                end else begin
                    // Old value kept; third miss lands on zero, i.e. blocked
                    e.tries        = e.tries - 2'h1;
                    e.verified     = 1'b0;
                    st_next.rsp_sw = retry_sw(e.tries);
                end
                st_next.ent[q_idx] = e;
            end
            default: begin
                st_next.state = pvc_pkg::ST_IDLE;
            end
        endcase

        if (link.acc_req) begin
            st_next.acc_valid = 1'b1;
            if (!qa_ok || (link.acc_two && !qb_ok)) begin
                st_next.acc_grant = 1'b0;
            end else if (link.acc_two) begin
                st_next.acc_grant = ea.disabled || eb.disabled || ga || gb;
            end else begin
                st_next.acc_grant = ga;
            end
        end

        // Counters survive a new session; only verification is forgotten
        if (session_start) begin
            for (int i = 0; i < 64; i++) begin
                st_next.ent[i].verified = 1'b0;
            end
        end

        if (link.rst) begin
            st_next = '0;
            for (int i = 0; i < 64; i++) begin
                st_next.ent[i].value = pvc_pkg::VALUE_RESET;
                st_next.ent[i].tries = pvc_pkg::TRIES_INIT;
            end
        end
    end

    always_ff @(posedge link.clock) begin
        st_reg <= st_next;
    end

    assign link.rsp_valid = st_reg.rsp_valid;
    assign link.rsp_sw    = st_reg.rsp_sw;
    assign link.acc_valid = st_reg.acc_valid;
    assign link.acc_grant = st_reg.acc_grant;
endmodule

//--- verilog/pvc_if.sv
`timescale 1ns/1ps
interface pvc_if (
    input wire logic clock,
    input wire logic rst
);
    logic         cmd_valid;
    logic [1:0]   cmd_op;
    logic [7:0]   cmd_p1;
    logic [7:0]   cmd_p2;
    logic [7:0]   cmd_lc;
    logic [127:0] cmd_data;
    logic         rsp_valid;
    logic [15:0]  rsp_sw;
    logic         acc_req;
    logic [7:0]   acc_qual_a;
    logic [7:0]   acc_qual_b;
    logic         acc_two;
    logic         acc_valid;
    logic         acc_grant;

    modport card (
        input  clock,
        input  rst,
        input  cmd_valid,
        input  cmd_op,
        input  cmd_p1,
        input  cmd_p2,
        input  cmd_lc,
        input  cmd_data,
        output rsp_valid,
        output rsp_sw,
        input  acc_req,
        input  acc_qual_a,
        input  acc_qual_b,
        input  acc_two,
        output acc_valid,
        output acc_grant
    );

    modport term (
        input  clock,
        input  rst,
        output cmd_valid,
        output cmd_op,
        output cmd_p1,
        output cmd_p2,
        output cmd_lc,
        output cmd_data,
        input  rsp_valid,
        input  rsp_sw,
        output acc_req,
        output acc_qual_a,
        output acc_qual_b,
        output acc_two,
        input  acc_valid,
        input  acc_grant
    );
endinterface

//--- verilog/pvc_pkg.sv
package pvc_pkg;

    // ------------------------------------------------------------
    // Command encoding and qualifier fields
    // ------------------------------------------------------------
    localparam logic [1:0]  OP_VERIFY    = 2'h0;
    localparam logic [1:0]  OP_CHANGE    = 2'h1;
    localparam logic [1:0]  OP_DISABLE   = 2'h2;
    localparam logic [7:0]  P1_PLAIN     = 8'h00;
    localparam logic [7:0]  LC_EMPTY     = 8'h00;
    localparam logic [7:0]  LC_ONE_VALUE = 8'h08;
    localparam logic [7:0]  LC_TWO_VALUE = 8'h10;
    localparam int          QUAL_SEL_BIT = 7;
    localparam int          QUAL_RSV_MSB = 6;
    localparam int          QUAL_RSV_LSB = 5;
    localparam int          QUAL_REF_MSB = 4;
    localparam logic [1:0]  TRIES_INIT   = 2'h3;
    localparam logic [63:0] VALUE_RESET  = 64'hFFFF_FFFF_FFFF_FFFF;

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    localparam logic [15:0] SW_OK        = 16'h9000;
    localparam logic [15:0] SW_RETRY     = 16'h63C0;
    localparam logic [15:0] SW_BLOCKED   = 16'h6983;
    localparam logic [15:0] SW_REFUSED   = 16'h6985;
    localparam logic [15:0] SW_BAD_PARAM = 16'h6B00;
    localparam logic [15:0] SW_BAD_LEN   = 16'h6700;
    localparam logic [15:0] SW_BAD_OP    = 16'h6D00;

    // ------------------------------------------------------------
    // Terminal-side register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CMD      = 8'h00;
    localparam logic [7:0]  OFS_OLD_HI   = 8'h04;
    localparam logic [7:0]  OFS_OLD_LO   = 8'h08;
    localparam logic [7:0]  OFS_NEW_HI   = 8'h0C;
    localparam logic [7:0]  OFS_NEW_LO   = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_ACC      = 8'h18;
    localparam logic [7:0]  OFS_ACC_RES  = 8'h1C;
    localparam int          CMD_EMPTY_BIT = 2;
    localparam int          CMD_REPL_BIT  = 3;
    localparam int          CMD_RREF_LSB  = 8;
    localparam int          CMD_P2_LSB    = 16;
    localparam int          ACC_B_LSB     = 8;
    localparam int          ACC_TWO_BIT   = 16;
    localparam int          STAT_DONE_BIT = 16;
    localparam int          STAT_BUSY_BIT = 17;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WORK = 2'b01
    } pvc_state_t;

    typedef struct packed {
        logic [63:0] value;
        logic [1:0]  tries;
        logic        disabled;
        logic        verified;
        logic        repl_use;
        logic [4:0]  repl_ref;
    } pvc_entry_t;

endpackage

//--- verilog/pvc_qual.sv
`timescale 1ns/1ps
module pvc_qual (
    input  wire logic [7:0] qual,
    output logic            ok,
    output logic [5:0]      idx
);
    // Zero byte fails here too, since reference number 0 is rejected
    assign ok  = (qual[pvc_pkg::QUAL_RSV_MSB:pvc_pkg::QUAL_RSV_LSB] == 2'h0) &&
                 (qual[pvc_pkg::QUAL_REF_MSB:0] != 5'h00);
    assign idx = {qual[pvc_pkg::QUAL_SEL_BIT], qual[pvc_pkg::QUAL_REF_MSB:0]};
endmodule

//--- verilog/pvc_term.sv
`timescale 1ns/1ps
module pvc_term (
    pvc_if.term              link,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata
);
    typedef struct packed {
        pvc_pkg::pvc_state_t state;
        logic                cmd_valid;
        logic [1:0]          op;
        logic [7:0]          p1;
        logic [7:0]          p2;
        logic [7:0]          lc;
        logic [127:0]        data;
        logic [63:0]         old_val;
        logic [63:0]         new_val;
        logic [15:0]         sw;
        logic                done;
        logic                acc_req;
        logic [7:0]          qa;
        logic [7:0]          qb;
        logic                two;
        logic                grant;
        logic                acc_done;
        logic [31:0]         rdata;
    } pvc_term_t;

    pvc_term_t st_reg;
    pvc_term_t st_next;

    always_comb begin
        logic [1:0] op;
        op                = wdata[1:0];
        st_next           = st_reg;
        st_next.cmd_valid = 1'b0;
        st_next.acc_req   = 1'b0;
        st_next.rdata     = 32'h0000_0000;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (wr) begin
            if (addr == pvc_pkg::OFS_CMD) begin
                // Launch only while idle; a write while busy is dropped
                if (st_reg.state == pvc_pkg::ST_IDLE) begin
                    st_next.op        = op;
                    st_next.p2        = wdata[pvc_pkg::CMD_P2_LSB +: 8];
                    st_next.data      = {st_reg.old_val, st_reg.new_val};
                    st_next.p1        = pvc_pkg::P1_PLAIN;
                    st_next.lc        = pvc_pkg::LC_ONE_VALUE;
                    if (op == pvc_pkg::OP_DISABLE && wdata[pvc_pkg::CMD_REPL_BIT]) begin
                        st_next.p1 = {3'h4, wdata[pvc_pkg::CMD_RREF_LSB +: 5]};
                    end
                    if (op == pvc_pkg::OP_CHANGE) begin
                        st_next.lc = pvc_pkg::LC_TWO_VALUE;
                    end else if (op == pvc_pkg::OP_VERIFY && wdata[pvc_pkg::CMD_EMPTY_BIT]) begin
                        st_next.lc = pvc_pkg::LC_EMPTY;
                    end
                    st_next.cmd_valid = 1'b1;
                    st_next.done      = 1'b0;
                    st_next.state     = pvc_pkg::ST_WORK;
                end
            end else if (addr == pvc_pkg::OFS_OLD_HI) begin
                st_next.old_val[63:32] = wdata;
            end else if (addr == pvc_pkg::OFS_OLD_LO) begin
                st_next.old_val[31:0] = wdata;
            end else if (addr == pvc_pkg::OFS_NEW_HI) begin
                st_next.new_val[63:32] = wdata;
            end else if (addr == pvc_pkg::OFS_NEW_LO) begin
                st_next.new_val[31:0] = wdata;
            end else if (addr == pvc_pkg::OFS_ACC) begin
                st_next.qa       = wdata[7:0];
                st_next.qb       = wdata[pvc_pkg::ACC_B_LSB +: 8];
                st_next.two      = wdata[pvc_pkg::ACC_TWO_BIT];
                st_next.acc_req  = 1'b1;
                st_next.acc_done = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // Answers from the card
        // ------------------------------------------------------------
        if (st_reg.state == pvc_pkg::ST_WORK && link.rsp_valid) begin
            st_next.sw    = link.rsp_sw;
            st_next.done  = 1'b1;
            st_next.state = pvc_pkg::ST_IDLE;
        end
        if (link.acc_valid) begin
            st_next.grant    = link.acc_grant;
            st_next.acc_done = 1'b1;
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        if (rd) begin
            if (addr == pvc_pkg::OFS_STATUS) begin
                st_next.rdata = {14'h0000, st_reg.state == pvc_pkg::ST_WORK,
                                 st_reg.done, st_reg.sw};
            end else if (addr == pvc_pkg::OFS_ACC_RES) begin
                st_next.rdata = {30'h0000_0000, st_reg.acc_done, st_reg.grant};
            end else if (addr == pvc_pkg::OFS_OLD_HI) begin
                st_next.rdata = st_reg.old_val[63:32];
            end else if (addr == pvc_pkg::OFS_OLD_LO) begin
                st_next.rdata = st_reg.old_val[31:0];
            end else if (addr == pvc_pkg::OFS_NEW_HI) begin
                st_next.rdata = st_reg.new_val[63:32];
            end else if (addr == pvc_pkg::OFS_NEW_LO) begin
                st_next.rdata = st_reg.new_val[31:0];
            end
        end

        if (link.rst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge link.clock) begin
        st_reg <= st_next;
    end

    assign link.cmd_valid  = st_reg.cmd_valid;
    assign link.cmd_op     = st_reg.op;
    assign link.cmd_p1     = st_reg.p1;
    assign link.cmd_p2     = st_reg.p2;
    assign link.cmd_lc     = st_reg.lc;
    assign link.cmd_data   = st_reg.data;
    assign link.acc_req    = st_reg.acc_req;
    assign link.acc_qual_a = st_reg.qa;
    assign link.acc_qual_b = st_reg.qb;
    assign link.acc_two    = st_reg.two;
    assign rdata           = st_reg.rdata;
endmodule
